// ===== hdl/arlt_pkg.sv
// Purpose: Shared constants and types for the auto-reload timer with capture
// Assumes: 25 MHz system clock, plain register port, byte-wide registers
// Notes: Offsets index byte registers on the plain port
package arlt_pkg;
  // Register offsets
  localparam logic [2:0] ARLT_OFF_CTRL = 3'h0;
  localparam logic [2:0] ARLT_OFF_CLKSEL = 3'h1;
  localparam logic [2:0] ARLT_OFF_RLD_LO = 3'h2;
  localparam logic [2:0] ARLT_OFF_RLD_HI = 3'h3;
  localparam logic [2:0] ARLT_OFF_CNT_LO = 3'h4;
  localparam logic [2:0] ARLT_OFF_CNT_HI = 3'h5;
  localparam logic [2:0] ARLT_OFF_IRQ_EN = 3'h6;
  // Control register bit positions
  localparam int ARLT_BIT_HOVF = 7;
  localparam int ARLT_BIT_LOVF = 6;
  localparam int ARLT_BIT_LIEN = 5;
  localparam int ARLT_BIT_CAPEN = 4;
  localparam int ARLT_BIT_SPLIT = 3;
  localparam int ARLT_BIT_RUN = 2;
  localparam int ARLT_BIT_XCLK = 0;
  // Clock select register bit positions
  localparam int ARLT_BIT_HFAST = 7;
  localparam int ARLT_BIT_LFAST = 6;
  // Reset values
  localparam logic [7:0] ARLT_RST_BYTE = 8'h00;
  localparam logic [3:0] ARLT_RST_DIV12 = 4'h0;
  localparam logic [2:0] ARLT_RST_DIV8 = 3'h0;
  // Divider and counter terminal counts
  localparam logic [3:0] ARLT_DIV12_LAST = 4'hb;
  localparam logic [7:0] ARLT_ALL_ONES = 8'hff;
  // Last synchronised rising edge of one external/8 period
  localparam logic [2:0] ARLT_DIV8_LAST = 3'h7;
  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } arlt_req_type;
  // All module state
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] clksel;
    logic irq_en;
    logic [7:0] rld_lo;
    logic [7:0] rld_hi;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic [3:0] div12;
    logic tick12;
    logic ext_s1;
    logic ext_s2;
    logic ext_d;
    logic [2:0] div8;
    logic tick8;
    logic cap;
    logic [7:0] rdata;
    logic irq;
  } arlt_state_type;
endpackage : arlt_pkg

// ===== hdl/arlt_timer.sv
// Purpose: Auto-reload up-counter, 16-bit or split 8-bit, with oscillator capture
// Assumes: ext_osc is asynchronous to clk_sys and far slower than it
// Notes: Every output is a flop; reads return data one cycle after rd
//
// Contract
// - Counter is two separately accessible bytes
// - Split bit picks 16-bit or dual 8-bit
// - Clocks: system, system/12, synchronised external/8
// - 16-bit wrap reloads and sets high flag unless capture is on
// - 16-bit overflow interrupts when enabled
// - Low byte wrap interrupts if low enable
// - Split bytes reload from own reload bytes
// - Split: run gates high byte only
// - Fast select wins, else external select decides
// - Split wraps set their own overflow flags
// - Split: high when enabled, low if low enable too, interrupts
// - Flags clear only by software write
// - Capture counts on system or system/12, except the split high byte
// - Capture copies counter to reload, sets flag
// - Capture on falling edge of external/8
// - Capture enable bit turns capture on
// - Low wrap sets low flag in every mode
`timescale 1ns/1ps
module arlt_timer
  import arlt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ext_osc,
  input wire arlt_pkg::arlt_req_type req,
  output logic [7:0] rdata,
  output logic irq,
  output logic high_overflow_flag,
  output logic low_overflow_flag
);
  import arlt_pkg::*;

  // Present and next state
  arlt_state_type s_reg;
  arlt_state_type s_next;

  // Tick chosen by a fast select and the external select
  function automatic logic pick_tick(input logic fast, input logic xclk,
                                     input logic t12, input logic t8);
    begin
      pick_tick = fast ? 1'b1 : (xclk ? t8 : t12);
    end
  endfunction : pick_tick

  // Working terms for the next-state process
  logic split;
  logic cap_on;
  logic run;
  logic lo_tick;
  logic hi_tick;
  logic lo_wrap;
  logic hi_wrap;
  logic hset;
  logic lset;
  logic [7:0] ctrl_w;

  // Next state: dividers, counting, flags, register port
  always_comb
  begin
    s_next = s_reg;
    split = s_reg.ctrl[ARLT_BIT_SPLIT];
    cap_on = s_reg.ctrl[ARLT_BIT_CAPEN];
    run = s_reg.ctrl[ARLT_BIT_RUN];
    lo_wrap = 1'b0;
    hi_wrap = 1'b0;
    hset = 1'b0;
    lset = 1'b0;
    ctrl_w = s_reg.ctrl;
    // System clock divided by 12
    s_next.tick12 = (s_reg.div12 == ARLT_DIV12_LAST);
    s_next.div12 = s_next.tick12 ? ARLT_RST_DIV12 : s_reg.div12 + 4'h1;
    // Two-flop synchroniser; only the second flop feeds logic
    s_next.ext_s1 = ext_osc;
    s_next.ext_s2 = s_reg.ext_s1;
    s_next.ext_d = s_reg.ext_s2;
    // External divided by 8: a 3-bit edge count, bit 2 is the /8 wave
    s_next.tick8 = 1'b0;
    s_next.cap = 1'b0;
    if (s_reg.ext_s2 && !s_reg.ext_d)
    begin
      s_next.div8 = s_reg.div8 + 3'h1;
      // One tick per eighth rising edge of the oscillator
      s_next.tick8 = (s_reg.div8 == ARLT_DIV8_LAST);
    end
    // Falling edge of the /8 wave, seen as div8 wrapping 7 to 0
    if (s_reg.ext_s2 && !s_reg.ext_d && s_reg.div8 == ARLT_DIV8_LAST)
    begin
      s_next.cap = cap_on;
    end
    // Tick selection; capture ignores the external path for the low tick only
    if (cap_on)
    begin
      lo_tick = pick_tick(s_reg.clksel[ARLT_BIT_LFAST], 1'b0,
                          s_reg.tick12, 1'b0);
    end
    else
    begin
      lo_tick = pick_tick(s_reg.clksel[ARLT_BIT_LFAST], s_reg.ctrl[ARLT_BIT_XCLK],
                          s_reg.tick12, s_reg.tick8);
    end
    hi_tick = pick_tick(s_reg.clksel[ARLT_BIT_HFAST], s_reg.ctrl[ARLT_BIT_XCLK],
                        s_reg.tick12, s_reg.tick8);
    if (split)
    begin
      // Low byte free-runs, high byte obeys run
      if (lo_tick)
      begin
        lo_wrap = (s_reg.cnt_lo == ARLT_ALL_ONES);
        s_next.cnt_lo = lo_wrap ? s_reg.rld_lo : s_reg.cnt_lo + 8'h01;
      end
      if (run && hi_tick)
      begin
        hi_wrap = (s_reg.cnt_hi == ARLT_ALL_ONES);
        s_next.cnt_hi = hi_wrap ? s_reg.rld_hi : s_reg.cnt_hi + 8'h01;
      end
      hset = hi_wrap;
    end
    else if (run && lo_tick)
    begin
      // 16-bit count shares the low byte's tick
      lo_wrap = (s_reg.cnt_lo == ARLT_ALL_ONES);
      hi_wrap = lo_wrap && (s_reg.cnt_hi == ARLT_ALL_ONES);
      if (hi_wrap && !cap_on)
      begin
        s_next.cnt_lo = s_reg.rld_lo;
        s_next.cnt_hi = s_reg.rld_hi;
      end
      else
      begin
        {s_next.cnt_hi, s_next.cnt_lo} = {s_reg.cnt_hi, s_reg.cnt_lo} + 16'h0001;
      end
      hset = hi_wrap && !cap_on;
    end
    lset = lo_wrap;
    // Capture copies the count into the reload pair
    if (s_reg.cap)
    begin
      s_next.rld_lo = s_reg.cnt_lo;
      s_next.rld_hi = s_reg.cnt_hi;
      hset = 1'b1;
    end
    // Register writes
    if (req.wr)
    begin
      case (req.addr)
        ARLT_OFF_CTRL: ctrl_w = req.wdata;
        ARLT_OFF_CLKSEL: s_next.clksel = req.wdata;
        ARLT_OFF_RLD_LO: s_next.rld_lo = req.wdata;
        ARLT_OFF_RLD_HI: s_next.rld_hi = req.wdata;
        ARLT_OFF_CNT_LO: s_next.cnt_lo = req.wdata;
        ARLT_OFF_CNT_HI: s_next.cnt_hi = req.wdata;
        ARLT_OFF_IRQ_EN: s_next.irq_en = req.wdata[0];
        default: ;
      endcase
    end
    // Unused bit reads zero; hardware set beats a software clear
    ctrl_w[1] = 1'b0;
    ctrl_w[ARLT_BIT_HOVF] = ctrl_w[ARLT_BIT_HOVF] | hset;
    ctrl_w[ARLT_BIT_LOVF] = ctrl_w[ARLT_BIT_LOVF] | lset;
    s_next.ctrl = ctrl_w;
    // Interrupt level follows the flags and enables
    s_next.irq = s_next.irq_en && (ctrl_w[ARLT_BIT_HOVF] ||
                 (ctrl_w[ARLT_BIT_LIEN] && ctrl_w[ARLT_BIT_LOVF]));
    // Read data stands one cycle after rd
    s_next.rdata = ARLT_RST_BYTE;
    if (req.rd)
    begin
      case (req.addr)
        ARLT_OFF_CTRL: s_next.rdata = s_reg.ctrl;
        ARLT_OFF_CLKSEL: s_next.rdata = s_reg.clksel;
        ARLT_OFF_RLD_LO: s_next.rdata = s_reg.rld_lo;
        ARLT_OFF_RLD_HI: s_next.rdata = s_reg.rld_hi;
        ARLT_OFF_CNT_LO: s_next.rdata = s_reg.cnt_lo;
        ARLT_OFF_CNT_HI: s_next.rdata = s_reg.cnt_hi;
        ARLT_OFF_IRQ_EN: s_next.rdata = {7'h00, s_reg.irq_en};
        default: s_next.rdata = ARLT_RST_BYTE;
      endcase
    end
  end

  // State register; constants only under reset
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flops
  assign rdata = s_reg.rdata;
  assign irq = s_reg.irq;
  assign high_overflow_flag = s_reg.ctrl[ARLT_BIT_HOVF];
  assign low_overflow_flag = s_reg.ctrl[ARLT_BIT_LOVF];
endmodule : arlt_timer

// ===== verif/arlt_timer_checker.sv
// Purpose: Port-level assertions for the auto-reload timer
// Assumes: Flags and irq are levels, rdata stands one cycle after rd
// Notes: Bound to every arlt_timer instance
`timescale 1ns/1ps
module arlt_timer_checker
  import arlt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ext_osc,
  input wire arlt_pkg::arlt_req_type req,
  input wire logic [7:0] rdata,
  input wire logic irq,
  input wire logic high_overflow_flag,
  input wire logic low_overflow_flag
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // Control write seen this cycle
  logic ctrl_wr;
  assign ctrl_wr = req.wr && req.addr == ARLT_OFF_CTRL;
  chk_rdata_idle_zero: assert property (!$past(req.rd) |-> rdata == 8'h00)
    else $error("rdata not zero outside read");
  chk_unmapped_reads_zero: assert property ($past(req.rd && req.addr == 3'h7) |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  // Gap of one idle cycle between write and read, as the bench does
  chk_ctrl_read_back: assert property (ctrl_wr ##2 (req.rd && req.addr == ARLT_OFF_CTRL)
    |=> (rdata & 8'h3f) == ($past(req.wdata, 3) & 8'h3d))
    else $error("control bits read back wrong");
  chk_clksel_read_back: assert property ((req.wr && req.addr == ARLT_OFF_CLKSEL)
    ##2 (req.rd && req.addr == ARLT_OFF_CLKSEL)
    |=> (rdata & 8'hc0) == ($past(req.wdata, 3) & 8'hc0))
    else $error("clock select read back wrong");
  chk_hflag_sw_clear: assert property ($fell(high_overflow_flag) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("high flag cleared without write");
  chk_lflag_sw_clear: assert property ($fell(low_overflow_flag) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("low flag cleared without write");
  chk_irq_has_flag: assert property ($rose(irq) |-> ##[0:1] (high_overflow_flag || low_overflow_flag))
    else $error("irq without a flag");
  chk_hflag_sw_set: assert property (ctrl_wr && req.wdata[ARLT_BIT_HOVF] |-> ##[1:2] high_overflow_flag)
    else $error("high flag not set by write");
  cover property ($rose(irq));
  cover property ($rose(high_overflow_flag));
  cover property ($rose(low_overflow_flag));
endmodule : arlt_timer_checker
bind arlt_timer arlt_timer_checker u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .ext_osc(ext_osc),
  .req(req), .rdata(rdata), .irq(irq), .high_overflow_flag(high_overflow_flag),
  .low_overflow_flag(low_overflow_flag));

// ===== verif/testbench.sv
// Purpose: Register-level tests of the auto-reload timer
// Assumes: 25 MHz clk_sys, ext_osc period of 8 clocks
// Notes: Rate checks allow one tick of slack for divider phase
`timescale 1ns/1ps
module testbench;
  import arlt_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ext_osc = 1'b0;
  arlt_req_type req = '0;
  logic [7:0] rdata, v, d;
  logic irq, hf, lf;
  logic [15:0] c1;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  arlt_timer DUT (.clk_sys(clk_sys), .rst_b(rst_b), .ext_osc(ext_osc), .req(req),
    .rdata(rdata), .irq(irq), .high_overflow_flag(hf), .low_overflow_flag(lf));
  initial forever #20 clk_sys = ~clk_sys;
  // Free-running oscillator plus hang guard
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc % 4 == 0) ext_osc <= ~ext_osc;
    if (cyc == 40000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD value exp %h seen %h", exp, seen);
    end
  endtask : check
  // Idle cycle after each strobe keeps drivers to one assignment a step
  task wr(input logic [2:0] a, input logic [7:0] dt);
    req <= '{addr: a, wdata: dt, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req <= '0;
    @(posedge clk_sys);
  endtask : wr
  task rd(input logic [2:0] a);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req <= '0;
    #1 v = rdata;
    @(posedge clk_sys);
  endtask : rd
  task wait_flag(input logic hi);
    for (int i = 0; i < 3000 && (hi ? hf : lf) !== 1'b1; i++) @(posedge clk_sys);
    check(hi ? hf : lf, 1'b1);
  endtask : wait_flag
  task wrap_up;
    if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    for (int a = 0; a < 8; a++)
    begin
      rd(a[2:0]);
      check(v, 8'h00);
      d = (a == 1) ? 8'hc0 : (a == 6) ? 8'h01 : 8'h11 * a[7:0];
      wr(a[2:0], d);
      rd(a[2:0]);
      if (a > 0) check(v, (a == 7) ? 8'h00 : d);
    end
    wr(ARLT_OFF_CTRL, 8'h2f);
    rd(ARLT_OFF_CTRL);
    check(v, 8'h2d);
    wr(ARLT_OFF_CTRL, 8'h80);
    check(hf, 1'b1);
    // 16-bit wrap from near all ones at system clock
    wr(ARLT_OFF_CLKSEL, 8'h40);
    wr(ARLT_OFF_RLD_HI, 8'hff);
    wr(ARLT_OFF_RLD_LO, 8'hf0);
    wr(ARLT_OFF_CNT_HI, 8'hff);
    wr(ARLT_OFF_CNT_LO, 8'hfd);
    wr(ARLT_OFF_CTRL, 8'h04);
    wait_flag(1'b1);
    check(lf, 1'b1);
    check(irq, 1'b1);
    repeat (10) @(posedge clk_sys);
    check({hf, lf}, 2'b11);
    wr(ARLT_OFF_CTRL, 8'h00);
    rd(ARLT_OFF_CNT_HI);
    check(v, 8'hff);
    check({hf, lf, irq}, 3'b000);
    // Low wrap interrupt with and without its enable
    for (int m = 0; m < 2; m++)
    begin
      wr(ARLT_OFF_CNT_HI, 8'h00);
      wr(ARLT_OFF_CNT_LO, 8'hfd);
      wr(ARLT_OFF_CTRL, m ? 8'h04 : 8'h24);
      wait_flag(1'b0);
      repeat (2) @(posedge clk_sys);
      check({hf, irq}, {1'b0, m == 0});
      wr(ARLT_OFF_CTRL, 8'h00);
    end
    // Split: low byte runs with run bit off, high byte held
    wr(ARLT_OFF_RLD_LO, 8'h80);
    wr(ARLT_OFF_CNT_HI, 8'h33);
    wr(ARLT_OFF_CNT_LO, 8'hfd);
    wr(ARLT_OFF_CTRL, 8'h08);
    wait_flag(1'b0);
    rd(ARLT_OFF_CTRL);
    check(v[7:6], 2'b01);
    rd(ARLT_OFF_CNT_HI);
    check(v, 8'h33);
    rd(ARLT_OFF_CNT_LO);
    check(v[7] && v < 8'h90, 1'b1);
    check({hf, irq}, 2'b00);
    wr(ARLT_OFF_CLKSEL, 8'hc0);
    wr(ARLT_OFF_RLD_HI, 8'hc0);
    wr(ARLT_OFF_CNT_HI, 8'hfe);
    wr(ARLT_OFF_CTRL, 8'h0c);
    wait_flag(1'b1);
    check(irq, 1'b1);
    rd(ARLT_OFF_CNT_HI);
    check(v >= 8'hc0, 1'b1);
    // Tick rates: system/12 and external/8, about ten ticks each
    wr(ARLT_OFF_CLKSEL, 8'h00);
    for (int m = 0; m < 2; m++)
    begin
      wr(ARLT_OFF_CTRL, 8'h00);
      wr(ARLT_OFF_CNT_LO, 8'h00);
      wr(ARLT_OFF_CTRL, m ? 8'h05 : 8'h04);
      repeat (m ? 640 : 120) @(posedge clk_sys);
      rd(ARLT_OFF_CNT_LO);
      check(v >= 8'h09 && v <= 8'h0b, 1'b1);
    end
    // Capture: successive captures one external/8 period apart
    wr(ARLT_OFF_CLKSEL, 8'h40);
    wr(ARLT_OFF_CTRL, 8'h14);
    wait_flag(1'b1);
    wr(ARLT_OFF_CTRL, 8'h14);
    wait_flag(1'b1);
    rd(ARLT_OFF_RLD_HI);
    c1[15:8] = v;
    rd(ARLT_OFF_RLD_LO);
    c1[7:0] = v;
    wr(ARLT_OFF_CTRL, 8'h14);
    wait_flag(1'b1);
    rd(ARLT_OFF_RLD_HI);
    d = v;
    rd(ARLT_OFF_RLD_LO);
    check({d, v} - c1, 16'h0040);
    wr(ARLT_OFF_CTRL, 8'h04);
    repeat (200) @(posedge clk_sys);
    check(hf, 1'b0);
    wrap_up();
  end
endmodule : testbench
